// File: rtl/address_field_decoder.sv
// Operand address generation with pointer register update
// What this block does
// - Short field: bits 4..2 pick the mode, bits 1..0 pick A4 to A7.
// - Modes 000/001 address the pointer, then add A0 or A1 to it.
// - Modes 010/011 address pointer plus scaled A0/A1; mode 100 addresses pointer.
// - Mode 101 addresses pointer, then pointer grows by the access size.
// - Mode 110 addresses pointer, then pointer shrinks by the access size.
// - Mode 111 shrinks pointer by the access size first, then addresses it.
// - Step and scale follow access width: 1/0, 2/1, 4/2, 8/3.
// - Scaled field holds a pointer select and an 8-bit unsigned offset.
// - Scaled field address is pointer plus offset times four, no update.
// - Selecting the stack pointer where invalid is flagged; the address is still issued.
// - Direct field bit 0 clear: address is the 32-bit absolute immediate.
// - Bit 0 set: pointer plus 28-bit offset split over opcode fields.
// - Negative stack offset has bits 13 to 31 forced to one.
// - The 13-bit field is the two's complement low part, -1 to -8192.
// - Stack address is stack pointer plus the extended negative offset.
// - The first-address field sits in opcode bits 31 to 16.
`timescale 1ns/10ps
module address_field_decoder
  import addr_gen_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic                  req_valid,
  input  wire field_kind_e           field_kind,
  input  wire access_width_e         access_width,
  input  wire logic [OPCODE_W-1:0]   opcode,
  input  wire logic                  direct_indirect,
  input  wire logic                  wr_en,
  input  wire logic [PTR_IDX_W-1:0]  wr_idx,
  input  wire logic [ADDR_W-1:0]     wr_data,
  input  wire logic [PTR_IDX_W-1:0]  rd_idx,
  output logic      [ADDR_W-1:0]     rd_data,
  output logic      [ADDR_W-1:0]     addr_q,
  output logic                       addr_valid_q,
  output logic                       sp_fault_q
);

  logic [ADDR_W-1:0]    ptrs [PTR_COUNT];
  logic [PTR_IDX_W-1:0] ptr_sel;
  logic [ADDR_W-1:0]    base;
  logic [ADDR_W-1:0]    index_reg;
  logic [ADDR_W-1:0]    step;
  logic [1:0]           scale;
  logic [ADDR_W-1:0]    addr_d;
  logic                 upd_en;
  logic [ADDR_W-1:0]    upd_val;
  logic                 sp_fault_d;
  logic [4:0]           short_field;
  logic [2:0]           short_mode;
  logic [11:0]          scaled_field;
  logic [NEG_OFF_W-1:0] neg_field;
  logic [27:0]          wide_offset;
  logic [ADDR_W-1:0]    abs_imm;
  logic [ADDR_W-1:0]    neg_offset;

  // Access width to shift amount; the step is one shifted by the same amount
  function automatic logic [1:0] width_scale(input access_width_e w);
    case (w)
      WIDTH_8:  width_scale = 2'h0;
      WIDTH_16: width_scale = 2'h1;
      WIDTH_32: width_scale = 2'h2;
      default:  width_scale = 2'h3;
    endcase
  endfunction

  assign scale = width_scale(access_width);
  assign step  = 32'h1 << width_scale(access_width);

  assign short_field  = opcode[SHORT_LSB +: 5];
  assign short_mode   = short_field[4:2];
  assign scaled_field = opcode[SCALED_LSB +: 12];
  assign neg_field    = opcode[FIRST_ADDR_LSB +: NEG_OFF_W];
  assign wide_offset  = {opcode[DIR_HI_LSB +: 16], opcode[DIR_LO_LSB +: 12]};
  assign abs_imm      = {opcode[DIR_HI_LSB +: 16], opcode[FIRST_ADDR_LSB +: 16]};
  assign neg_offset   = {NEG_PAD, neg_field};

  assign base      = ptrs[ptr_sel];
  assign index_reg = short_mode[0] ? ptrs[IDX_A1] : ptrs[IDX_A0];

  // Sums are kept at 32 bits so carries out of bit 31 drop
  always_comb
  begin
    ptr_sel    = SP_IDX;
    addr_d     = '0;
    upd_en     = 1'b0;
    upd_val    = '0;
    sp_fault_d = 1'b0;
    case (field_kind)
      KIND_SHORT:
      begin
        ptr_sel = {UPPER_BANK_BASE, short_field[1:0]};
        case (short_mode)
          MODE_POST_A0, MODE_POST_A1:
          begin
            addr_d  = base;
            upd_en  = 1'b1;
            upd_val = base + index_reg;
          end
          MODE_IDX_A0, MODE_IDX_A1:
            addr_d = base + (index_reg << scale);
          MODE_PLAIN:
            addr_d = base;
          MODE_POST_INC:
          begin
            addr_d  = base;
            upd_en  = 1'b1;
            upd_val = base + step;
          end
          MODE_POST_DEC:
          begin
            addr_d  = base;
            upd_en  = 1'b1;
            upd_val = base - step;
          end
          default:
          begin
            upd_en  = 1'b1;
            upd_val = base - step;
            addr_d  = base - step;
          end
        endcase
      end
      KIND_SCALED:
      begin
        ptr_sel    = scaled_field[SCALED_SEL_LSB +: PTR_IDX_W];
        addr_d     = base + {22'h0, scaled_field[7:0], 2'h0};
        sp_fault_d = (ptr_sel == SP_IDX);
      end
      KIND_DIRECT:
      begin
        if (!direct_indirect)
          addr_d = abs_imm;
        else
        begin
          ptr_sel    = opcode[DIR_SEL_LSB +: PTR_IDX_W];
          addr_d     = base + {4'h0, wide_offset};
          sp_fault_d = (ptr_sel == SP_IDX);
        end
      end
      default:
      begin
        ptr_sel = SP_IDX;
        addr_d  = base + neg_offset;
      end
    endcase
  end

  // A write from the core outranks an addressing update to the same pointer
  for (genvar i = 0; i < PTR_COUNT; i++)
  begin : g_ptr
    always_ff @(posedge mclk)
    begin
      if (!resetn)
        ptrs[i] <= PTR_RESET;
      else if (wr_en && (wr_idx == PTR_IDX_W'(i)))
        ptrs[i] <= wr_data;
      else if (req_valid && upd_en && (ptr_sel == PTR_IDX_W'(i)))
        ptrs[i] <= upd_val;
    end
  end

  assign rd_data = ptrs[rd_idx];

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      addr_q <= '0;
    else if (req_valid)
      addr_q <= addr_d;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      addr_valid_q <= 1'b0;
    else
      addr_valid_q <= req_valid;
  end

  // Fault is reported, the address is still produced; squashing is the core's job
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      sp_fault_q <= 1'b0;
    else
      sp_fault_q <= req_valid && sp_fault_d;
  end

  sequence s_short(logic [2:0] code);
    req_valid && !wr_en && field_kind == KIND_SHORT && short_mode == code;
  endsequence

  sequence s_kind(field_kind_e k);
    req_valid && !wr_en && field_kind == k;
  endsequence

  chk_valid_follows: assert property (@(posedge mclk) disable iff (!resetn)
    req_valid |=> addr_valid_q ##1 (addr_valid_q == $past(req_valid)))
    else $error("address valid does not follow request");

  chk_post_add_a0: assert property (@(posedge mclk) disable iff (!resetn)
    s_short(MODE_POST_A0) |=> addr_q == $past(base)
      && ptrs[$past(ptr_sel)] == $past(base) + $past(ptrs[IDX_A0]))
    else $error("post add of A0 wrong");

  chk_index_scaled: assert property (@(posedge mclk) disable iff (!resetn)
    s_short(MODE_IDX_A1) |=> addr_q == $past(base) + ($past(ptrs[IDX_A1]) << $past(scale))
      && ptrs[$past(ptr_sel)] == $past(base))
    else $error("indexed mode wrong or pointer changed");

  chk_post_inc_step: assert property (@(posedge mclk) disable iff (!resetn)
    s_short(MODE_POST_INC) ##0 (access_width == WIDTH_64) |=> addr_q == $past(base)
      && ptrs[$past(ptr_sel)] == $past(base) + 32'h8)
    else $error("post increment step wrong");

  chk_post_dec_step: assert property (@(posedge mclk) disable iff (!resetn)
    s_short(MODE_POST_DEC) ##0 (access_width == WIDTH_16) |=> addr_q == $past(base)
      && ptrs[$past(ptr_sel)] == $past(base) - 32'h2)
    else $error("post decrement step wrong");

  chk_pre_dec_addr: assert property (@(posedge mclk) disable iff (!resetn)
    s_short(MODE_PRE_DEC) |=> addr_q == ptrs[$past(ptr_sel)]
      && addr_q == $past(base) - $past(step))
    else $error("pre decrement address wrong");

  chk_scaled_offset: assert property (@(posedge mclk) disable iff (!resetn)
    s_kind(KIND_SCALED) |=> addr_q == $past(base) + ($past(opcode[7:0]) * 32'h4)
      && ptrs[$past(ptr_sel)] == $past(base))
    else $error("scaled offset address wrong");

  chk_direct_abs: assert property (@(posedge mclk) disable iff (!resetn)
    s_kind(KIND_DIRECT) ##0 !direct_indirect |=> addr_q[15:0] == $past(opcode[31:16])
      && addr_q[31:16] == $past(opcode[47:32]))
    else $error("absolute address wrong");

  chk_stack_neg: assert property (@(posedge mclk) disable iff (!resetn)
    s_kind(KIND_STACK) |=> addr_q == $past(ptrs[SP_IDX]) - (NEG_SPAN - $past(opcode[28:16])))
    else $error("stack negative offset address wrong");

  chk_sp_fault: assert property (@(posedge mclk) disable iff (!resetn)
    s_kind(KIND_SCALED) ##0 (scaled_field[11:8] == SP_IDX) |=> sp_fault_q ##1 1'b1)
    else $error("stack pointer select not flagged");

endmodule

// File: shared/addr_gen_pkg.sv
// Constants, encodings and field positions for operand address generation
package addr_gen_pkg;

  localparam int ADDR_W     = 32;
  localparam int PTR_COUNT  = 16;
  localparam int PTR_IDX_W  = 4;
  localparam int OPCODE_W   = 48;

  localparam logic [ADDR_W-1:0]    PTR_RESET = 32'h0;
  localparam logic [PTR_IDX_W-1:0] IDX_A0    = 4'h0;
  localparam logic [PTR_IDX_W-1:0] IDX_A1    = 4'h1;
  localparam logic [PTR_IDX_W-1:0] SP_IDX    = 4'hf;
  // Short pointer field reaches only A4 to A7
  localparam logic [1:0]           UPPER_BANK_BASE = 2'h1;

  // Which address field the current instruction carries
  typedef enum logic [1:0]
  {
    KIND_SHORT  = 2'b00,
    KIND_SCALED = 2'b01,
    KIND_DIRECT = 2'b11,
    KIND_STACK  = 2'b10
  } field_kind_e;

  typedef enum logic [1:0]
  {
    WIDTH_8  = 2'b00,
    WIDTH_16 = 2'b01,
    WIDTH_32 = 2'b10,
    WIDTH_64 = 2'b11
  } access_width_e;

  // Mode codes of the short pointer field, bits 4 to 2
  localparam logic [2:0] MODE_POST_A0  = 3'h0;
  localparam logic [2:0] MODE_POST_A1  = 3'h1;
  localparam logic [2:0] MODE_IDX_A0   = 3'h2;
  localparam logic [2:0] MODE_IDX_A1   = 3'h3;
  localparam logic [2:0] MODE_PLAIN    = 3'h4;
  localparam logic [2:0] MODE_POST_INC = 3'h5;
  localparam logic [2:0] MODE_POST_DEC = 3'h6;
  localparam logic [2:0] MODE_PRE_DEC  = 3'h7;

  // Field positions within the opcode
  localparam int SHORT_LSB      = 0;
  localparam int SCALED_LSB     = 0;
  localparam int SCALED_SEL_LSB = 8;
  localparam int FIRST_ADDR_LSB = 16;
  localparam int DIR_SEL_LSB    = 16;
  localparam int DIR_LO_LSB     = 20;
  localparam int DIR_HI_LSB     = 32;

  localparam int BYTE_OFF_SHIFT = 2;
  localparam int NEG_OFF_W      = 13;
  localparam logic [18:0] NEG_PAD  = 19'h7ffff;
  localparam logic [31:0] NEG_SPAN = 32'h00002000;

endpackage

// File: tb/tb.sv
// Self-checking bench for the operand address generator
`timescale 1ns/10ps
module tb;
  import addr_gen_pkg::*;
  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic              fault;
    logic [ADDR_W-1:0] rdv;
  } note_s;
  logic                 mclk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 req_valid = 1'b0;
  field_kind_e          field_kind = KIND_SHORT;
  access_width_e        access_width = WIDTH_8;
  logic [OPCODE_W-1:0]  opcode = '0;
  logic                 direct_indirect = 1'b0;
  logic                 wr_en = 1'b0;
  logic [PTR_IDX_W-1:0] wr_idx = '0;
  logic [ADDR_W-1:0]    wr_data = '0;
  logic [PTR_IDX_W-1:0] rd_idx = '0;
  logic [ADDR_W-1:0]    rd_data;
  logic [ADDR_W-1:0]    addr_q;
  logic                 addr_valid_q;
  logic                 sp_fault_q;
  logic [ADDR_W-1:0]    ptr [16];
  note_s                q [$];
  integer               seed = 32'he54d;
  int                   error_cnt = 0;
  int                   num_checks = 0;
  int                   cycles = 0;

  address_field_decoder address_field_decoder_inst (.mclk(mclk), .resetn(resetn),
    .req_valid(req_valid), .field_kind(field_kind), .access_width(access_width),
    .opcode(opcode), .direct_indirect(direct_indirect), .wr_en(wr_en), .wr_idx(wr_idx),
    .wr_data(wr_data), .rd_idx(rd_idx), .rd_data(rd_data), .addr_q(addr_q),
    .addr_valid_q(addr_valid_q), .sp_fault_q(sp_fault_q));

  always #2 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Checks made %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic idle;
    @(negedge mclk);
    req_valid = 1'b0;
    wr_en = 1'b0;
  endtask

  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    @(negedge mclk);
    req_valid = 1'b0;
    wr_en = 1'b1;
    wr_idx = i;
    wr_data = d;
    ptr[i] = d;
  endtask

  // The model advances its pointers at drive time, matching the edge-aligned update
  task automatic do_req(input field_kind_e k, input access_width_e w,
                        input logic [47:0] op, input logic di);
    logic [31:0] a, p, np, step;
    logic [3:0]  sel;
    note_s       n;
    step = 32'h1 << w;
    n.fault = 1'b0;
    sel = 4'h4 + {2'h0, op[1:0]};
    p = ptr[sel];
    a = p;
    case (k)
      KIND_SHORT:
      begin
        np = p;
        case (op[4:2])
          MODE_POST_A0:  np = p + ptr[0];
          MODE_POST_A1:  np = p + ptr[1];
          MODE_IDX_A0:   a = p + (ptr[0] << w);
          MODE_IDX_A1:   a = p + (ptr[1] << w);
          MODE_POST_INC: np = p + step;
          MODE_POST_DEC: np = p - step;
          MODE_PRE_DEC:  np = p - step;
          default:       np = p;
        endcase
        if (op[4:2] == MODE_PRE_DEC) a = np;
        ptr[sel] = np;
      end
      KIND_SCALED:
      begin
        sel = op[11:8];
        a = ptr[sel] + {22'h0, op[7:0], 2'h0};
        n.fault = (sel == 4'hf);
      end
      KIND_DIRECT:
      begin
        sel = op[19:16];
        a = {op[47:32], op[31:16]};
        if (di) a = ptr[sel] + {4'h0, op[47:32], op[31:20]};
        n.fault = di && (sel == 4'hf);
      end
      default: a = ptr[15] + {19'h7ffff, op[28:16]};
    endcase
    n.addr = a;
    n.rdv = ptr[sel];
    @(negedge mclk);
    wr_en = 1'b0;
    req_valid = 1'b1;
    field_kind = k;
    access_width = w;
    opcode = op;
    direct_indirect = di;
    rd_idx = sel;
    q.push_back(n);
  endtask

  always @(posedge mclk)
  begin
    note_s n;
    #1;
    if (addr_valid_q === 1'b1)
    begin
      if (q.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        n = q.pop_front();
        check(addr_q, n.addr);
        check({31'h0, sp_fault_q}, {31'h0, n.fault});
        check(rd_data, n.rdv);
      end
    end
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  initial
  begin
    logic [31:0] r;
    logic [47:0] op;
    logic [12:0] neg_vals [7];
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    #1;
    check(rd_data, 32'h0);
    for (int i = 0; i < 16; i++) wr(i[3:0], $random(seed));
    for (int m = 0; m < 32; m++)
    begin
      r = $random(seed);
      op = {r, 11'h0, m[4:2], r[1:0]};
      do_req(KIND_SHORT, access_width_e'(m[1:0]), op, 1'b0);
    end
    wr(4'h4, 32'hfffffffc);
    do_req(KIND_SHORT, WIDTH_64, 48'h14, 1'b0);
    wr(4'hf, 32'h00000100);
    // End points of the negative offset range and both sides of its midpoint
    neg_vals = '{13'h1fff, 13'h1ffe, 13'h1001, 13'h1000, 13'h0fff, 13'h0001, 13'h0000};
    foreach (neg_vals[j])
      do_req(KIND_STACK, WIDTH_32, {19'h0, neg_vals[j], 16'h0}, 1'b0);
    for (int v = 0; v < 8192; v += 1365)
      do_req(KIND_STACK, WIDTH_32, {19'h0, 13'h1fff - v[12:0], 16'h0}, 1'b0);
    do_req(KIND_STACK, WIDTH_32, 48'h0, 1'b0);
    for (int i = 0; i < 300; i++)
    begin
      r = $random(seed);
      op = {r[15:0], 32'($random(seed))};
      if (r[31:28] == 4'h0) wr(r[23:20], $random(seed));
      do_req(field_kind_e'(r[17:16]), access_width_e'(r[19:18]), op, r[24]);
    end
    repeat (4) idle();
    check(32'(q.size()), 32'h0);
    print_verdict();
  end
endmodule
